// File: spi_pkg.sv
/*
 Constants, field positions and types shared by the serial interface core.
 Assumes one 8-bit register space and one core clock.
*/
// Operation
// - Interrupt enable raises a request when either flag sets alone.
// - Interrupt source bit picks external pin or serial request.
// - Output enable cleared keeps all serial pins as inputs.
// - Select low while master clears output enable and master select.
// - Master select chooses role; master drives clock and swaps data pins.
// - Clock idle level sets the clock level between transfers.
// - Clock phase picks first or second edge as capture edge.
// - Rate code divides core clock by 2, 4, 16 or 32; code scales this by prescale+1, and by 2 while the half bit is clear.
// - Rate code has no effect in slave role.
// - Master transfer starts only on a data register write.
// - Received byte goes to a buffer at completion; reads return buffer.
// - Data write loads the transmit shift register directly.
// - Complete flag sets at end of byte, reads zero otherwise.
// - Complete flag clears by status access then data access.
// - Data writes are ignored while the complete flag is set.
// - Data write during a transfer sets collision flag, never interrupts.
// - Select low while master sets the mode fault flag.
// - Mode fault clears by status access then control write.
// - Status register is read only and resets to zero.
// - Control register is read write and resets to zero.
// - Each byte is eight clock pulses, shifting out and in together.
// - Output enable and master select refused while fault set, except clearing.
// - Slave select low freezes the data register against writes.
package spi_pkg;

    localparam logic [7:0] DATA_OFS  = 8'hf0;
    localparam logic [7:0] CTRL_OFS  = 8'hf1;
    localparam logic [7:0] STAT_OFS  = 8'hf2;
    localparam logic [7:0] PRESC_OFS = 8'hf3;

    localparam int CTRL_IE   = 7;
    localparam int CTRL_OE   = 6;
    localparam int CTRL_SRC  = 5;
    localparam int CTRL_MASTER_SELECT = 4;
    localparam int CTRL_CLOCK_IDLE_LEVEL = 3;
    localparam int CTRL_CLOCK_PHASE = 2;
    localparam int STAT_TRANSFER_COMPLETE_FLAG = 7;
    localparam int STAT_WRITE_COLLISION_FLAG = 6;
    localparam int STAT_MODE_FAULT_FLAG = 4;
    localparam int PRESC_HALF = 4;

    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] PRESC_RESET = 8'h00;
    localparam logic [7:0] PRESC_MASK  = 8'h17;
    localparam logic [7:0] RX_RESET    = 8'h00;

    // Half-period multipliers for rate codes 00..11
    localparam logic [4:0] RATE_HALF_0 = 5'h01;
    localparam logic [4:0] RATE_HALF_1 = 5'h02;
    localparam logic [4:0] RATE_HALF_2 = 5'h08;
    localparam logic [4:0] RATE_HALF_3 = 5'h10;

    // Sixteen clock edges make eight pulses
    localparam logic [3:0] EDGE_LAST = 4'hf;

    typedef enum logic [1:0] {
        XFER_IDLE   = 2'b00,
        XFER_MASTER = 2'b01,
        XFER_SLAVE  = 2'b10
    } xfer_mode_t;

endpackage

// File: spi_rate_gen.sv
/*
 Master clock half-period tick generator.
 Assumes i_run is high only while a master byte is on the wire.
*/
module spi_rate_gen (
    input  wire logic       i_core_clk,  // Core clock
    input  wire logic       i_reset,     // Async reset, high
    input  wire logic       i_run,       // Count while high
    input  wire logic [2:0] i_prescale,  // Prescale value
    input  wire logic       i_half_div,  // One disables extra divide by two
    input  wire logic [1:0] i_rate_sel,  // Rate code
    output logic            o_tick       // One pulse per half period
);
    import spi_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic       tick;
    } rate_state_t;

    rate_state_t state_reg;
    rate_state_t state_next;
    logic [4:0]  rate_half;
    logic [8:0]  limit;

    always_comb begin
        unique case (i_rate_sel)
            2'b00: rate_half = RATE_HALF_0;
            2'b01: rate_half = RATE_HALF_1;
            2'b10: rate_half = RATE_HALF_2;
            2'b11: rate_half = RATE_HALF_3;
        endcase
    end

    assign limit = ({6'h00, i_prescale} + 9'h001)
                 * ({8'h00, ~i_half_div} + 9'h001)
                 * {4'h0, rate_half};

    // idle in slave role, so rate bits do nothing
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!i_run) begin
            state_next.cnt = 9'h000;
        end else if (state_reg.cnt == limit - 9'h001) begin
            state_next.cnt  = 9'h000;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 9'h001;
        end
    end

    // State register
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_tick = state_reg.tick;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    chk_tick_idle: assert property (!i_run |=> !o_tick)
        else $error("rate tick while not running");
    chk_fast_rate: assert property (
        i_run && i_rate_sel == 2'b00 && i_prescale == 3'h0 && i_half_div
        ##1 i_run |-> o_tick)
        else $error("divide by two rate missed a tick");
endmodule

// File: spi_ctrl.sv
/*
 Serial peripheral core: data, control, status and prescale registers,
 byte shift engine for master and slave, pin drive and interrupt request.
 Assumes synchronous pin inputs; the pad ring resolves pins from the enables.
*/
// Local design decision: strobed register access.
module spi_ctrl (
    input  wire logic       i_core_clk,  // Core clock, 250 MHz
    input  wire logic       i_reset,     // Async reset, high
    input  wire logic [7:0] i_addr,      // Register address
    input  wire logic [7:0] i_wdata,     // Write data
    input  wire logic       i_wr,        // Write strobe
    input  wire logic       i_rd,        // Read strobe
    output logic      [7:0] o_rdata,     // Read data, cycle after strobe
    input  wire logic       i_ext_irq,   // External interrupt pin
    output logic            o_irq,       // Shared interrupt channel
    input  wire logic       i_ss_n,      // Slave select, low active
    input  wire logic       i_sck,       // Clock pin input
    output logic            o_sck,       // Clock pin output
    output logic            o_sck_oe,    // Clock pin enable
    input  wire logic       i_mosi,      // Master-out pin input
    output logic            o_mosi,      // Master-out pin output
    output logic            o_mosi_oe,   // Master-out pin enable
    input  wire logic       i_miso,      // Master-in pin input
    output logic            o_miso,      // Master-in pin output
    output logic            o_miso_oe    // Master-in pin enable
);
    import spi_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] presc;
        logic       transfer_complete_flag;
        logic       write_collision_flag;
        logic       mode_fault_flag;
        logic       transfer_complete_flag_armed;
        logic       write_collision_flag_armed;
        logic       mode_fault_flag_armed;
        logic [7:0] rxbuf;
        logic [7:0] shreg;
        logic       cap;
        logic [3:0] edge_cnt;
        xfer_mode_t mode;
        logic       sck_lvl;
        logic       sck_prev;
        logic [7:0] rdata;
        logic       irq;
        logic       sck_oe;
        logic       mosi_oe;
        logic       miso_oe;
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;

    logic tick;
    logic data_wr;
    logic data_rd;
    logic ctrl_wr;
    logic stat_acc;
    logic data_acc;
    logic is_master;
    logic ss_act;
    logic sck_edge;
    logic step;
    logic cap_edge;
    logic in_bit;
    logic last_bit;

    // Baud tick only counts while a master byte runs
    spi_rate_gen u_rate (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_run      (state_reg.mode == XFER_MASTER),
        .i_prescale (state_reg.presc[2:0]),
        .i_half_div (state_reg.presc[PRESC_HALF]),
        .i_rate_sel (state_reg.ctrl[1:0]),
        .o_tick     (tick)
    );

    // Address decode and pin qualifiers
    assign data_wr   = i_wr && (i_addr == DATA_OFS);
    assign data_rd   = i_rd && (i_addr == DATA_OFS);
    assign ctrl_wr   = i_wr && (i_addr == CTRL_OFS);
    assign stat_acc  = (i_rd || i_wr) && (i_addr == STAT_OFS);
    assign data_acc  = (i_rd || i_wr) && (i_addr == DATA_OFS);
    assign is_master = state_reg.ctrl[CTRL_MASTER_SELECT];
    assign ss_act    = !i_ss_n;
    assign sck_edge  = i_sck != state_reg.sck_prev;

    // master samples the slave line, slave the master line
    assign in_bit = is_master ? i_miso : i_mosi;

    // capture on even edges for phase 0, odd for phase 1
    assign cap_edge = state_reg.edge_cnt[0] == state_reg.ctrl[CTRL_CLOCK_PHASE];
    assign last_bit = cap_edge ? in_bit : state_reg.cap;

    // Engine advances on own tick as master, on pin edges as slave
    always_comb begin
        unique case (state_reg.mode)
            XFER_IDLE:   step = 1'b0;
            XFER_MASTER: step = tick;
            XFER_SLAVE:  step = sck_edge && ss_act;
            default:     step = 1'b0;
        endcase
    end

    // Next-state logic; clears come before sets so a set always wins
    always_comb begin
        state_next = state_reg;
        state_next.sck_prev = i_sck;

        // Register read mux, answer one cycle later
        state_next.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                // reads return the buffer, not the shifter
                DATA_OFS:  state_next.rdata = state_reg.rxbuf;
                CTRL_OFS:  state_next.rdata = state_reg.ctrl;
                STAT_OFS: begin
                    state_next.rdata[STAT_TRANSFER_COMPLETE_FLAG] = state_reg.transfer_complete_flag;
                    state_next.rdata[STAT_WRITE_COLLISION_FLAG] = state_reg.write_collision_flag;
                    state_next.rdata[STAT_MODE_FAULT_FLAG] = state_reg.mode_fault_flag;
                end
                PRESC_OFS: state_next.rdata = state_reg.presc;
                default:   state_next.rdata = 8'h00;
            endcase
        end

        // status access arms the flags that are set
        if (stat_acc) begin
            state_next.transfer_complete_flag_armed = state_reg.transfer_complete_flag;
            state_next.write_collision_flag_armed = state_reg.write_collision_flag;
            state_next.mode_fault_flag_armed = state_reg.mode_fault_flag;
        end

        // armed complete and collision flags drop on the data access
        if (data_acc) begin
            if (state_reg.transfer_complete_flag_armed) begin
                state_next.transfer_complete_flag = 1'b0;
            end
            if (state_reg.write_collision_flag_armed) begin
                state_next.write_collision_flag = 1'b0;
            end
            state_next.transfer_complete_flag_armed = 1'b0;
            state_next.write_collision_flag_armed = 1'b0;
        end

        // control writes; status writes fall through
        if (ctrl_wr) begin
            state_next.ctrl = i_wdata;
            // enables refused while fault is set and unarmed
            if (state_reg.mode_fault_flag && !state_reg.mode_fault_flag_armed) begin
                state_next.ctrl[CTRL_OE]   = 1'b0;
                state_next.ctrl[CTRL_MASTER_SELECT] = 1'b0;
            end
            // control write completes the fault clear
            if (state_reg.mode_fault_flag_armed) begin
                state_next.mode_fault_flag = 1'b0;
            end
            state_next.mode_fault_flag_armed = 1'b0;
        end

        if (i_wr && i_addr == PRESC_OFS) begin
            state_next.presc = i_wdata & PRESC_MASK;
        end

        // Shift engine, one step per clock edge
        if (step) begin
            state_next.edge_cnt = state_reg.edge_cnt + 4'h1;
            if (state_reg.mode == XFER_MASTER) begin
                state_next.sck_lvl = !state_reg.sck_lvl;
            end
            if (cap_edge) begin
                state_next.cap = in_bit;
            end
            // eighth bit ends the byte after sixteen edges
            if (state_reg.edge_cnt == EDGE_LAST) begin
                state_next.shreg = {state_reg.shreg[6:0], last_bit};
                // received byte copied to the buffer
                state_next.rxbuf = {state_reg.shreg[6:0], last_bit};
                state_next.transfer_complete_flag  = 1'b1;
                state_next.mode  = XFER_IDLE;
            end else if (!cap_edge && !(state_reg.ctrl[CTRL_CLOCK_PHASE]
                         && state_reg.edge_cnt == 4'h0)) begin
                state_next.shreg = {state_reg.shreg[6:0], state_reg.cap};
            end
        end

        // Slave byte framed by select; select high aborts a partial byte
        if (state_reg.mode == XFER_SLAVE && !ss_act) begin
            state_next.mode = XFER_IDLE;
        end
        if (state_reg.mode == XFER_IDLE && !is_master && ss_act) begin
            state_next.mode     = XFER_SLAVE;
            state_next.edge_cnt = 4'h0;
        end

        // Data register writes
        if (data_wr) begin
            if (state_reg.transfer_complete_flag) begin
                // write dropped while complete flag is set
                state_next.write_collision_flag = state_next.write_collision_flag;
            end else if (state_reg.mode != XFER_IDLE
                         || (!is_master && ss_act)) begin
                state_next.write_collision_flag = 1'b1;
            end else begin
                state_next.shreg = i_wdata;
                if (is_master) begin
                    state_next.mode     = XFER_MASTER;
                    state_next.edge_cnt = 4'h0;
                end
            end
        end

        // select low as master: fault, drop enables, abort a byte already running
        if (is_master && ss_act) begin
            // fault flag set wins over its clear
            state_next.mode_fault_flag            = 1'b1;
            state_next.ctrl[CTRL_OE]   = 1'b0;
            state_next.ctrl[CTRL_MASTER_SELECT] = 1'b0;
            if (state_reg.mode == XFER_MASTER) begin
                state_next.mode = XFER_IDLE;
            end
        end

        // clock rests at the idle level outside master bytes
        if (state_next.mode != XFER_MASTER) begin
            state_next.sck_lvl = state_next.ctrl[CTRL_CLOCK_IDLE_LEVEL];
        end

        // master drives clock and master-out, slave master-in
        state_next.sck_oe  = state_next.ctrl[CTRL_OE]
                           && state_next.ctrl[CTRL_MASTER_SELECT];
        state_next.mosi_oe = state_next.ctrl[CTRL_OE]
                           && state_next.ctrl[CTRL_MASTER_SELECT];
        state_next.miso_oe = state_next.ctrl[CTRL_OE]
                           && !state_next.ctrl[CTRL_MASTER_SELECT] && ss_act;

        // select external pin or own request
        if (state_reg.ctrl[CTRL_SRC]) begin
            // level rises when the complete or the mode fault flag sets
            state_next.irq = state_reg.ctrl[CTRL_IE]
                           && (state_reg.transfer_complete_flag || state_reg.mode_fault_flag);
        end else begin
            state_next.irq = i_ext_irq;
        end
    end

    // State register, all zero after reset
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg       <= '0;
            state_reg.ctrl  <= CTRL_RESET;
            state_reg.presc <= PRESC_RESET;
            state_reg.rxbuf <= RX_RESET;
            state_reg.mode  <= XFER_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign o_rdata   = state_reg.rdata;
    assign o_irq     = state_reg.irq;
    assign o_sck     = state_reg.sck_lvl;
    assign o_sck_oe  = state_reg.sck_oe;
    assign o_mosi    = state_reg.shreg[7];
    assign o_mosi_oe = state_reg.mosi_oe;
    assign o_miso    = state_reg.shreg[7];
    assign o_miso_oe = state_reg.miso_oe;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    chk_irq_gate_off: assert property (
        state_reg.ctrl[CTRL_SRC] && !state_reg.ctrl[CTRL_IE] |=> !o_irq)
        else $error("request raised with interrupts disabled");

    chk_irq_ext_route: assert property (
        !state_reg.ctrl[CTRL_SRC] |=> o_irq == $past(i_ext_irq))
        else $error("external source not routed");

    chk_pins_input: assert property (
        !state_next.ctrl[CTRL_OE] |=> !o_sck_oe && !o_mosi_oe && !o_miso_oe)
        else $error("pin driven with output enable clear");

    chk_mode_fault_flag_drop: assert property (
        is_master && ss_act |=> state_reg.mode_fault_flag && !state_reg.ctrl[CTRL_OE]
                                && !state_reg.ctrl[CTRL_MASTER_SELECT])
        else $error("mode fault not taken");

    chk_master_start: assert property (
        state_reg.mode == XFER_IDLE ##1 state_reg.mode == XFER_MASTER
        |-> $past(data_wr))
        else $error("master byte began without data write");

    chk_rx_read: assert property (
        data_rd |=> o_rdata == $past(state_reg.rxbuf))
        else $error("data read did not return buffer");

    chk_transfer_complete_flag_block: assert property (
        state_reg.transfer_complete_flag && data_wr && state_reg.mode == XFER_IDLE
        |=> state_reg.mode != XFER_MASTER)
        else $error("write accepted while complete flag set");

    chk_write_collision_flag_set: assert property (
        data_wr && !state_reg.transfer_complete_flag && state_reg.mode == XFER_MASTER
        |=> state_reg.write_collision_flag)
        else $error("collision not flagged");

    chk_ctrl_guard: assert property (
        ctrl_wr && state_reg.mode_fault_flag && !state_reg.mode_fault_flag_armed
        |=> !state_reg.ctrl[CTRL_OE] && !state_reg.ctrl[CTRL_MASTER_SELECT])
        else $error("enables accepted during mode fault");

    chk_stat_ro: assert property (
        i_wr && i_addr == STAT_OFS && !step && !(is_master && ss_act)
        |=> state_reg.transfer_complete_flag == $past(state_reg.transfer_complete_flag)
            && state_reg.mode_fault_flag == $past(state_reg.mode_fault_flag))
        else $error("status write changed a flag");
endmodule

// File: spi_peer_model.sv
/*
 Behavioural serial slave on the far side of the core's master link.
 Assumes clock and data wires are already resolved from every enable.
*/
module spi_peer_model (
    input  wire logic       i_sck,    // Resolved clock wire
    input  wire logic       i_mosi,   // Resolved master-out wire
    input  wire logic       i_sel_n,  // Select, low active
    input  wire logic       i_clock_phase,   // Phase to follow
    input  wire logic [7:0] i_tx,     // Byte to return
    output logic            o_miso,   // Master-in drive
    output logic      [7:0] o_rx      // Byte received
);
    timeunit 1ns;
    timeprecision 1ps;
    int         edges = 0;
    logic [7:0] sh    = 8'h00;

    // Load the reply when selected
    always @(negedge i_sel_n) begin
        sh = i_tx;
        edges = 0;
    end

    always @(i_sck) begin
        if (!i_sel_n) begin
            edges++;
            if (edges[0] != i_clock_phase) begin
                o_rx = {o_rx[6:0], i_mosi};
            end else if (edges != 1) begin
                sh = sh << 1;
            end
        end
    end

    // Released line shows the inverse of the last bit, so no stale value passes
    assign o_miso = i_sel_n ? ~sh[7] : sh[7];
endmodule

// File: spi_control_status_irq_tb.sv
/*
 Self-checking bench for the serial core: registers, both roles, faults, interrupt.
 Assumes the behavioural slave model on the far side of the master link.
*/
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module spi_control_status_irq_tb import spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ext_irq = 1'b0;
    logic       ss_n = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0, peer_sel_n = 1'b1, clock_phase = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, peer_tx = 8'h00, v, r, c, d, m;
    wire  [7:0] rdata, peer_rx;
    wire        irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, peer_miso;
    wire        sck_w, mosi_w, miso_w, peer_mosi;
    int         errors = 0, comparisons = 0, ntog = 0, t1 = 0, t2 = 0, cyc = 0;
    int         hv[4] = '{1, 2, 8, 16};
    logic [7:0] exp_q[$];

    always #2 clk = ~clk;

    // Wire levels from every party's enable
    assign sck_w  = sck_oe ? sck : tb_sck;
    assign mosi_w = mosi_oe ? mosi : tb_mosi;
    assign miso_w = miso_oe ? miso : peer_miso;

    // Peer sees master-out 1 ns late, like a pad delay, so a shift on a capture edge cannot race
    assign #1 peer_mosi = mosi_w;

    spi_ctrl i_dut (
        .i_core_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_irq(ext_irq), .o_irq(irq),
        .i_ss_n(ss_n), .i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe),
        .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
        .i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe)
    );

    spi_peer_model i_peer (
        .i_sck(sck_w), .i_mosi(peer_mosi), .i_sel_n(peer_sel_n), .i_clock_phase(clock_phase),
        .i_tx(peer_tx), .o_miso(peer_miso), .o_rx(peer_rx)
    );

    // Cycle count and clock toggle timestamps for the rate checks
    always @(posedge clk) cyc++;
    always @(sck) begin
        ntog++;
        if (ntog == 1) t1 = cyc;
        if (ntog == 2) t2 = cyc;
    end

    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk);
        addr <= a;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] dv);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        dv = rdata;
    endtask

    // One master byte; the peer's reply goes through the model queue
    task automatic xfer(input logic [7:0] cv, input logic [7:0] dv, input int h,
                        input logic coll);
        logic [7:0] tx;
        tx = 8'($urandom);
        exp_q.push_back(tx);
        peer_tx <= tx;
        clock_phase <= cv[CTRL_CLOCK_PHASE];
        tb_sck <= cv[CTRL_CLOCK_IDLE_LEVEL];
        wreg(CTRL_OFS, cv);
        repeat (3) @(posedge clk);
        peer_sel_n <= 1'b0;
        wreg(DATA_OFS, dv);
        ntog = 0;
        `CHK(irq, 1'b0)
        if (coll) begin
            wreg(DATA_OFS, 8'h5a);
            rreg(STAT_OFS, v);
            `CHK(v, 8'h40)
            `CHK(irq, 1'b0)
        end
        v = 8'h00;
        for (int k = 0; k < 1000 && v[STAT_TRANSFER_COMPLETE_FLAG] !== 1'b1; k++) begin
            rreg(STAT_OFS, v);
        end
        `CHK(v[STAT_TRANSFER_COMPLETE_FLAG], 1'b1)
        `CHK(v[STAT_WRITE_COLLISION_FLAG], coll)
        repeat (2) @(posedge clk);
        `CHK(irq, cv[CTRL_IE])
        `CHK(t2 - t1, h)
        `CHK(peer_rx, dv)
        wreg(DATA_OFS, ~dv);
        repeat (40) @(posedge clk);
        `CHK(ntog, 16)
        rreg(DATA_OFS, r);
        `CHK(r, exp_q.pop_front())
        rreg(STAT_OFS, v);
        `CHK(v, 8'h00)
        `CHK(v & 8'h90, 8'h00)
        `CHK(irq, 1'b0)
        peer_sel_n <= 1'b1;
    endtask

    // Watchdog sized well beyond the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'he253));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rreg(CTRL_OFS, v);
        `CHK(v, 8'h00)
        wreg(STAT_OFS, 8'hff);
        rreg(STAT_OFS, v);
        `CHK(v, 8'h00)
        rreg(8'h37, v);
        `CHK(v, 8'h00)
        wreg(CTRL_OFS, 8'h1c);
        repeat (3) @(posedge clk);
        `CHK({sck_oe, mosi_oe, miso_oe}, 3'b000)
        `CHK(sck, 1'b1)
        c = 8'($urandom);
        wreg(CTRL_OFS, c);
        rreg(CTRL_OFS, v);
        `CHK(v, c)
        `CHK(sck_oe, c[CTRL_OE] & c[CTRL_MASTER_SELECT])
        // External pin routed through when the source bit is clear
        wreg(CTRL_OFS, 8'h80);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clk);
            ext_irq <= k[0];
            repeat (3) @(posedge clk);
            #1;
            `CHK(irq, k[0])
        end
        // Select pulled low on an enabled master
        wreg(CTRL_OFS, 8'hf0);
        ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        ss_n <= 1'b1;
        rreg(CTRL_OFS, v);
        `CHK(v, 8'ha0)
        `CHK(irq, 1'b1)
        wreg(CTRL_OFS, 8'hf0);
        rreg(CTRL_OFS, v);
        `CHK(v, 8'ha0)
        rreg(STAT_OFS, v);
        `CHK(v, 8'h10)
        wreg(CTRL_OFS, 8'hd0);
        rreg(STAT_OFS, v);
        `CHK(v, 8'h00)
        rreg(CTRL_OFS, v);
        `CHK(v, 8'hd0)
        // Slave byte clocked by the bench, rate bits set to no effect
        wreg(CTRL_OFS, 8'h43);
        c = 8'($urandom);
        d = 8'($urandom);
        wreg(DATA_OFS, c);
        ss_n <= 1'b0;
        repeat (2) @(posedge clk);
        wreg(DATA_OFS, ~c);
        `CHK({miso_oe, mosi_oe, sck_oe}, 3'b100)
        for (int b = 7; b >= 0; b--) begin
            @(posedge clk);
            tb_mosi <= d[b];
            repeat (4) @(posedge clk);
            m = {m[6:0], miso_w};
            tb_sck <= 1'b1;
            repeat (4) @(posedge clk);
            tb_sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        rreg(STAT_OFS, v);
        `CHK(v, 8'hc0)
        rreg(DATA_OFS, v);
        `CHK(v, d)
        `CHK(m, c)
        ss_n <= 1'b1;
        rreg(STAT_OFS, v);
        `CHK(v, 8'h00)
        // Master bytes over every rate, polarity and phase
        wreg(PRESC_OFS, 8'h10);
        for (int i = 0; i < 8; i++) begin
            if (i == 7) begin
                wreg(PRESC_OFS, 8'h02);
            end
            c = {i[0], 1'b1, i[0], 1'b1, i[2], i[1], i[1:0]};
            xfer(c, 8'($urandom), hv[i % 4] * (i == 7 ? 6 : 1), i == 7);
        end
        conclude();
    end
endmodule
